// file: hdl/ssb_exec.sv
// Execution slice: set-all-ones, power-down, subtract-with-borrow
`timescale 1ns/1ps
`include "ssb_defs.svh"
module ssb_exec (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        CLK_EN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [31:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        WATCHDOG_WAKE,
  input  wire logic        OTHER_WAKE,
  output logic             WATCHDOG_CLEAR,
  output logic             OSC_STOPPED,
  output logic             IRQ
);
  ssb_pkg::ssb_state_t state;
  ssb_pkg::ssb_state_t next_state;

  logic [15:0] instr;
  logic [7:0]  acc;
  logic [7:0]  status;
  logic [3:0]  bank_select_reg;
  logic        extended_set;
  logic [7:0]  index_base;
  logic [7:0]  general_purpose_file [0:255];
  logic [7:0]  opnd;
  logic [7:0]  res;
  logic [4:0]  res_flags;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  logic        wd_wake_s1;
  logic        wd_wake_s2;
  logic        ot_wake_s1;
  logic        ot_wake_s2;
  logic        wd_clr;
  logic        ack;
  logic [31:0] rdata;

  function automatic logic [7:0] ssb_file_index(input logic [7:0] f, input logic a, input logic ext,
                                                input logic [3:0] bank, input logic [7:0] base);
    logic [7:0] idx;
    idx = {bank[3:0], f[3:0]};
    if (!a && ext && f <= `SSB_INDEXED_LIMIT) begin
      idx = base + f;
    end else if (!a) begin
      idx = (f < `SSB_ACCESS_SPLIT) ? f : f;
    end else begin
      idx = f;
    end
    return idx;
  endfunction

  // Register file here is 256 bytes: banked addresses fold onto the low byte
  wire        is_sleep  = (instr == `SSB_OP_SLEEP);
  wire        is_sub    = ((instr & `SSB_OP_SUB_MASK) == `SSB_OP_SUB_VAL);
  wire        is_set    = ((instr & `SSB_OP_SET_MASK) == `SSB_OP_SET_VAL);
  wire        dest_file = instr[`SSB_BIT_DEST];
  wire        acc_bit   = instr[`SSB_BIT_ACCESS];
  wire [7:0]  fidx      = ssb_file_index(instr[7:0], acc_bit, extended_set, bank_select_reg, index_base);
  wire [7:0]  alu_res;
  wire        alu_c;
  wire        alu_dc;
  wire        alu_ov;
  wire        alu_n;
  wire        alu_z;

  ssb_alu u_alu (
    .acc               (acc),
    .opnd              (opnd),
    .carry_in          (status[`SSB_ST_C]),
    .result            (alu_res),
    .carry             (alu_c),
    .half_byte_carry   (alu_dc),
    .signed_range_flag (alu_ov),
    .negative          (alu_n),
    .zero              (alu_z)
  );

  // Bus decode
  wire        bus_req   = WB_CYC_I && WB_STB_I && !ack;
  // Writes land at the edge that sees ack high, as the master expects
  wire        bus_wr    = WB_CYC_I && WB_STB_I && ack && WB_WE_I && WB_SEL_I[0];
  wire        hit_ctrl  = (WB_ADR_I == `SSB_ADR_CTRL);
  wire        hit_instr = (WB_ADR_I == `SSB_ADR_INSTR);
  wire        hit_acc   = (WB_ADR_I == `SSB_ADR_ACC);
  wire        hit_stat  = (WB_ADR_I == `SSB_ADR_STATUS);
  wire        hit_bank  = (WB_ADR_I == `SSB_ADR_BANK);
  wire        hit_istat = (WB_ADR_I == `SSB_ADR_IRQ_STAT);
  wire        hit_imask = (WB_ADR_I == `SSB_ADR_IRQ_MASK);
  wire        hit_file  = (WB_ADR_I[31:10] == 22'(`SSB_ADR_FILE_BASE >> 10));
  wire [7:0]  bus_fidx  = WB_ADR_I[9:2];
  wire        busy      = (state != ssb_pkg::SSB_IDLE) && (state != ssb_pkg::SSB_HALT);
  wire        start     = bus_wr && hit_ctrl && WB_DAT_I[0] && !busy && state != ssb_pkg::SSB_HALT;
  wire        wd_wake   = wd_wake_s2 && state == ssb_pkg::SSB_HALT;
  wire        any_wake  = (wd_wake_s2 || ot_wake_s2) && state == ssb_pkg::SSB_HALT;
  wire        q4_write  = state == ssb_pkg::SSB_Q4 && (is_set || (is_sub && dest_file));
  wire        q4_sub    = state == ssb_pkg::SSB_Q4 && is_sub;
  wire        q4_sleep  = state == ssb_pkg::SSB_Q4 && is_sleep;
  wire [2:0]  ev        = {wd_wake || (any_wake && !wd_wake), q4_sleep,
                           state == ssb_pkg::SSB_Q4 && !is_sleep};

  assign rdata = hit_ctrl  ? {22'h0, index_base, extended_set, busy} :
                 hit_instr ? {16'h0, instr} :
                 hit_acc   ? {24'h0, acc} :
                 hit_stat  ? {24'h0, status} :
                 hit_bank  ? {28'h0, bank_select_reg} :
                 hit_istat ? {29'h0, irq_stat} :
                 hit_imask ? {29'h0, irq_mask} :
                 hit_file  ? {24'h0, general_purpose_file[bus_fidx]} : 32'h0;

  // Phase sequencer: decode in Q1 on start, then Q2, Q3, Q4
  always_comb begin
    next_state = state;
    case (state)
      ssb_pkg::SSB_IDLE: next_state = start ? ssb_pkg::SSB_Q2 : ssb_pkg::SSB_IDLE;
      ssb_pkg::SSB_Q2:   next_state = ssb_pkg::SSB_Q3;
      ssb_pkg::SSB_Q3:   next_state = ssb_pkg::SSB_Q4;
      ssb_pkg::SSB_Q4:   next_state = is_sleep ? ssb_pkg::SSB_HALT : ssb_pkg::SSB_IDLE;
      ssb_pkg::SSB_HALT: next_state = any_wake ? ssb_pkg::SSB_IDLE : ssb_pkg::SSB_HALT;
      default:           next_state = ssb_pkg::SSB_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state <= ssb_pkg::SSB_IDLE;
    end else if (CLK_EN) begin
      state <= next_state;
    end
  end

  // Wake pins come from outside the clock domain
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wd_wake_s1 <= 1'b0;
      wd_wake_s2 <= 1'b0;
      ot_wake_s1 <= 1'b0;
      ot_wake_s2 <= 1'b0;
    end else if (CLK_EN) begin
      wd_wake_s1 <= WATCHDOG_WAKE;
      wd_wake_s2 <= wd_wake_s1;
      ot_wake_s1 <= OTHER_WAKE;
      ot_wake_s2 <= ot_wake_s1;
    end
  end

  // Operand read in Q2; sleep does nothing here
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      opnd <= 8'h00;
    end else if (CLK_EN && state == ssb_pkg::SSB_Q2 && !is_sleep) begin
      opnd <= general_purpose_file[fidx];
    end
  end

  // Result latched in Q3
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      res       <= 8'h00;
      res_flags <= 5'h00;
    end else if (CLK_EN && state == ssb_pkg::SSB_Q3) begin
      res       <= is_set ? `SSB_ALL_ONES : alu_res;
      res_flags <= {alu_n, alu_ov, alu_z, alu_dc, alu_c};
    end
  end

  // File write in Q4; bus writes only when idle or halted
  always_ff @(posedge CLOCK) begin
    if (CLK_EN) begin
      if (q4_write) begin
        general_purpose_file[fidx] <= res;
      end else if (bus_wr && hit_file && !busy) begin
        general_purpose_file[bus_fidx] <= WB_DAT_I[7:0];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      acc             <= 8'h00;
      instr           <= 16'h0000;
      bank_select_reg <= 4'h0;
      extended_set    <= 1'b0;
      index_base      <= 8'h00;
    end else if (CLK_EN) begin
      if (q4_sub && !dest_file) begin
        acc <= res;
      end else if (bus_wr && hit_acc && !busy) begin
        acc <= WB_DAT_I[7:0];
      end
      if (bus_wr && hit_instr && !busy) begin
        instr <= WB_DAT_I[15:0];
      end
      if (bus_wr && hit_bank && !busy) begin
        bank_select_reg <= WB_DAT_I[3:0];
      end
      if (bus_wr && hit_ctrl && !busy) begin
        extended_set <= WB_DAT_I[1];
        index_base   <= WB_DAT_I[9:2];
      end
    end
  end

  // Status: arithmetic flags from subtract, power flags from sleep and watchdog wake
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      status <= `SSB_STATUS_RESET;
    end else if (CLK_EN) begin
      if (q4_sub) begin
        status[4:0] <= {res_flags[4], res_flags[3], res_flags[2], res_flags[1], res_flags[0]};
      end else if (bus_wr && hit_stat && !busy) begin
        status[4:0] <= WB_DAT_I[4:0];
      end
      if (q4_sleep) begin
        status[`SSB_ST_PD] <= 1'b0;
        status[`SSB_ST_TO] <= 1'b1;
      end else if (wd_wake) begin
        status[`SSB_ST_TO] <= 1'b0;
      end
    end
  end

  // Watchdog and postscaler clear pulse, held by the watchdog outside
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wd_clr <= 1'b0;
    end else if (CLK_EN) begin
      wd_clr <= q4_sleep;
    end
  end

  // Sticky events; set wins over a write-one clear
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end else if (CLK_EN) begin
      irq_stat <= (irq_stat & ~((bus_wr && hit_istat) ? WB_DAT_I[2:0] : 3'h0)) | ev;
      if (bus_wr && hit_imask) begin
        irq_mask <= WB_DAT_I[2:0];
      end
    end
  end

  // Ack one cycle after the request; frozen like the rest when disabled
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ack      <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else if (CLK_EN) begin
      ack      <= bus_req;
      WB_DAT_O <= rdata;
    end
  end

  assign WB_ACK_O       = ack;
  assign WATCHDOG_CLEAR = wd_clr;
  assign OSC_STOPPED    = (state == ssb_pkg::SSB_HALT);
  assign IRQ            = |(irq_stat & irq_mask);
endmodule

// file: hdl/ssb_defs.svh
// Constants for the power-down and subtract-with-borrow execution slice
`ifndef SSB_DEFS_SVH
`define SSB_DEFS_SVH

`define SSB_OP_SLEEP        16'h0003
`define SSB_OP_SUB_MASK     16'hfc00
`define SSB_OP_SUB_VAL      16'h5400
`define SSB_OP_SET_MASK     16'hfe00
`define SSB_OP_SET_VAL      16'h6800
`define SSB_BIT_DEST        9
`define SSB_BIT_ACCESS      8
`define SSB_ALL_ONES        8'hff
`define SSB_INDEXED_LIMIT   8'h5f
`define SSB_ACCESS_SPLIT    8'h60
`define SSB_ACCESS_HIGH_BANK 4'hf

`define SSB_ADR_CTRL        32'h0000_0000
`define SSB_ADR_INSTR       32'h0000_0004
`define SSB_ADR_ACC         32'h0000_0008
`define SSB_ADR_STATUS      32'h0000_000c
`define SSB_ADR_BANK        32'h0000_0010
`define SSB_ADR_IRQ_STAT    32'h0000_0014
`define SSB_ADR_IRQ_MASK    32'h0000_0018
`define SSB_ADR_FILE_BASE   32'h0000_0400

`define SSB_ST_C            0
`define SSB_ST_DC           1
`define SSB_ST_Z            2
`define SSB_ST_OV           3
`define SSB_ST_N            4
`define SSB_ST_PD           5
`define SSB_ST_TO           6

`define SSB_EV_DONE         0
`define SSB_EV_SLEEP        1
`define SSB_EV_WAKE         2

`define SSB_STATUS_RESET    8'h60

`endif

// file: hdl/ssb_pkg.sv
// Types for the power-down and subtract-with-borrow execution slice
package ssb_pkg;
  typedef enum logic [4:0] {
    SSB_IDLE  = 5'h01,
    SSB_Q2    = 5'h02,
    SSB_Q3    = 5'h04,
    SSB_Q4    = 5'h08,
    SSB_HALT  = 5'h10
  } ssb_state_t;
endpackage

// file: hdl/ssb_alu.sv
// Subtract-with-borrow datapath with flag results
`timescale 1ns/1ps
module ssb_alu (
  input  wire logic [7:0] acc,
  input  wire logic [7:0] opnd,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic            carry,
  output logic            half_byte_carry,
  output logic            signed_range_flag,
  output logic            negative,
  output logic            zero
);
  // Carry is an inverted borrow: a + ~b + c
  wire [8:0] full_sum;
  wire [4:0] low_sum;
  assign full_sum = {1'b0, acc} + {1'b0, ~opnd} + {8'h00, carry_in};
  assign low_sum  = {1'b0, acc[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, carry_in};
  assign result            = full_sum[7:0];
  assign carry             = full_sum[8];
  assign half_byte_carry   = low_sum[4];
  assign signed_range_flag = (acc[7] != opnd[7]) && (full_sum[7] != acc[7]);
  assign negative          = full_sum[7];
  assign zero              = (full_sum[7:0] == 8'h00);
endmodule

// file: verification/ssb_exec_sva.sv
// Port assertions for the execution slice
`timescale 1ns/1ps
module ssb_exec_sva (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic CLK_EN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic WATCHDOG_WAKE,
  input wire logic OTHER_WAKE,
  input wire logic WATCHDOG_CLEAR,
  input wire logic OSC_STOPPED
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held too long");
  a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN |=> WB_ACK_O)
    else $error("ack missing");
  a_ack_needs_req: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_clear_at_halt: assert property ($rose(OSC_STOPPED) |-> ##[0:1] WATCHDOG_CLEAR)
    else $error("watchdog not cleared on halt");
  a_clear_one_pulse: assert property (WATCHDOG_CLEAR |=> !WATCHDOG_CLEAR)
    else $error("clear pulse too long");
  a_clear_in_halt: assert property (WATCHDOG_CLEAR |-> OSC_STOPPED)
    else $error("clear outside halt");
  a_wdt_wake_exit: assert property (OSC_STOPPED && WATCHDOG_WAKE |-> ##[1:4] !OSC_STOPPED)
    else $error("no exit on watchdog wake");
  a_other_wake_exit: assert property (OSC_STOPPED && OTHER_WAKE |-> ##[1:4] !OSC_STOPPED)
    else $error("no exit on wake");
  a_halt_holds: assert property ((OSC_STOPPED && !WATCHDOG_WAKE && !OTHER_WAKE) [*4] |=> OSC_STOPPED)
    else $error("left halt unwoken");
endmodule
bind ssb_exec ssb_exec_sva u_sva (.CLOCK(CLOCK), .SRST(SRST), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WATCHDOG_WAKE(WATCHDOG_WAKE), .OTHER_WAKE(OTHER_WAKE),
  .WATCHDOG_CLEAR(WATCHDOG_CLEAR), .OSC_STOPPED(OSC_STOPPED));

// file: verification/ssb_exec_bench.sv
// Self-checking bench for the execution slice
`timescale 1ns/1ps
`include "ssb_defs.svh"
module ssb_exec_bench;
  logic        CLOCK = 1'h0, SRST = 1'h1, CLK_EN = 1'h1, WB_CYC_I = 1'h0, WB_STB_I = 1'h0, WB_WE_I = 1'h0;
  logic        WATCHDOG_WAKE = 1'h0, OTHER_WAKE = 1'h0, WB_ACK_O, WATCHDOG_CLEAR, OSC_STOPPED, IRQ;
  logic [31:0] WB_ADR_I = 32'h0, WB_DAT_I = 32'h0, WB_DAT_O, rd, r;
  logic [3:0]  WB_SEL_I = 4'hf;
  logic [12:0] ex;
  int          miscompares = 0, checks_done = 0, clears = 0;
  ssb_exec dut (.CLOCK(CLOCK), .SRST(SRST), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .WATCHDOG_WAKE(WATCHDOG_WAKE), .OTHER_WAKE(OTHER_WAKE),
    .WATCHDOG_CLEAR(WATCHDOG_CLEAR), .OSC_STOPPED(OSC_STOPPED), .IRQ(IRQ));
  always #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (WATCHDOG_CLEAR === 1'h1) clears++;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, then one idle cycle before the next
  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    WB_CYC_I <= 1'h1;
    WB_STB_I <= 1'h1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= dat;
    do begin
      @(posedge CLOCK);
      n++;
    end while (WB_ACK_O !== 1'h1 && n < 20);
    rd = WB_DAT_O;
    if (n >= 20) miscompares++;
    WB_CYC_I <= 1'h0;
    WB_STB_I <= 1'h0;
    WB_WE_I <= 1'h0;
    @(posedge CLOCK);
  endtask
  task automatic run(input logic [31:0] ctrl);
    int n;
    n = 0;
    wb(1'h1, `SSB_ADR_CTRL, ctrl);
    do begin
      wb(1'h0, `SSB_ADR_CTRL, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 20);
    if (n >= 20) miscompares++;
  endtask
  task automatic wait_osc(input logic lvl);
    int n;
    n = 0;
    while (OSC_STOPPED !== lvl && n < 20) begin
      @(posedge CLOCK);
      n++;
    end
    if (n >= 20) miscompares++;
  endtask
  // Flags packed as N OV Z DC C above the result byte
  function automatic logic [12:0] sub_exp(input logic [7:0] w, input logic [7:0] f, input logic cy);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'h0, w} - {1'h0, f} - {8'h0, ~cy};
    h = {1'h0, w[3:0]} - {1'h0, f[3:0]} - {4'h0, ~cy};
    return {s[7], (w[7] != f[7]) && (s[7] != w[7]), s[7:0] == 8'h0, ~h[4], ~s[8], s[7:0]};
  endfunction
  initial begin
    #100000;
    miscompares++;
    finish_test;
  end
  initial begin
    r = $urandom(32'hdd2782cc);
    repeat (6) @(posedge CLOCK);
    SRST <= 1'h0;
    @(posedge CLOCK);
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      // Corner cases first: borrow down to all ones, then a plain borrow-free step
      if (i == 0) r[26:0] = {3'h7, 8'h03, 8'h03, 8'h02};
      if (i == 1) r[26:0] = {3'h5, 8'h10, 8'h02, 8'h05};
      ex = sub_exp(r[7:0], r[15:8], r[26]);
      wb(1'h1, `SSB_ADR_FILE_BASE + {22'h0, r[23:16], 2'h0}, {24'h0, r[15:8]});
      wb(1'h1, `SSB_ADR_ACC, {24'h0, r[7:0]});
      wb(1'h1, `SSB_ADR_STATUS, {31'h0, r[26]});
      wb(1'h1, `SSB_ADR_INSTR, {16'h0, 6'h15, r[25:24], r[23:16]});
      run(32'h1);
      wb(1'h0, `SSB_ADR_ACC, 32'h0);
      check(rd, {24'h0, r[25] ? r[7:0] : ex[7:0]});
      wb(1'h0, `SSB_ADR_FILE_BASE + {22'h0, r[23:16], 2'h0}, 32'h0);
      check(rd, {24'h0, r[25] ? ex[7:0] : r[15:8]});
      wb(1'h0, `SSB_ADR_STATUS, 32'h0);
      check(rd & 32'h1f, {27'h0, ex[12:8]});
    end
    $display("test subtract done");
    wb(1'h1, `SSB_ADR_FILE_BASE + 32'h54, 32'h5a);
    wb(1'h1, `SSB_ADR_FILE_BASE + 32'h14, 32'h0);
    wb(1'h1, `SSB_ADR_STATUS, 32'h1f);
    wb(1'h1, `SSB_ADR_INSTR, 32'h6805);
    run(32'h43);
    wb(1'h0, `SSB_ADR_FILE_BASE + 32'h54, 32'h0);
    check(rd, 32'hff);
    wb(1'h0, `SSB_ADR_FILE_BASE + 32'h14, 32'h0);
    check(rd, 32'h0);
    wb(1'h0, `SSB_ADR_STATUS, 32'h0);
    check(rd & 32'h1f, 32'h1f);
    wb(1'h0, 32'h0000_0200, 32'h0);
    check(rd, 32'h0);
    $display("test set all ones done");
    for (int k = 0; k < 2; k++) begin
      wb(1'h1, `SSB_ADR_IRQ_MASK, 32'h2);
      wb(1'h1, `SSB_ADR_INSTR, {16'h0, `SSB_OP_SLEEP});
      wb(1'h1, `SSB_ADR_CTRL, 32'h1);
      wait_osc(1'h1);
      repeat (2) @(posedge CLOCK);
      check(clears, k + 1);
      wb(1'h0, `SSB_ADR_STATUS, 32'h0);
      check(rd & 32'h60, 32'h40);
      check({31'h0, IRQ}, 32'h1);
      wb(1'h1, `SSB_ADR_IRQ_MASK, 32'h0);
      check({31'h0, IRQ}, 32'h0);
      wb(1'h1, `SSB_ADR_IRQ_MASK, 32'h2);
      wb(1'h1, `SSB_ADR_IRQ_STAT, 32'h2);
      check({31'h0, IRQ}, 32'h0);
      if (k == 0) WATCHDOG_WAKE <= 1'h1;
      else OTHER_WAKE <= 1'h1;
      @(posedge CLOCK);
      wait_osc(1'h0);
      WATCHDOG_WAKE <= 1'h0;
      OTHER_WAKE <= 1'h0;
      wb(1'h0, `SSB_ADR_STATUS, 32'h0);
      check(rd & 32'h60, k == 0 ? 32'h0 : 32'h40);
    end
    $display("test power down done");
    finish_test;
  end
endmodule
